// File: rtl/crs_defines.vh
// shared constants of the configuration register sequencer
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// packet header fields
`define CRS_HDR_TYPE_HI 31
`define CRS_HDR_TYPE_LO 29
`define CRS_HDR_OP_HI 28
`define CRS_HDR_OP_LO 27
`define CRS_HDR_ADDR_HI 17
`define CRS_HDR_ADDR_LO 13
`define CRS_HDR_CNT1_HI 10
`define CRS_HDR_CNT2_HI 26
`define CRS_TYPE_ONE 3'h1
`define CRS_TYPE_TWO 3'h2
`define CRS_OP_WRITE 2'h2
`define CRS_OP_READ 2'h1
// register addresses
`define CRS_REG_CHECKSUM 5'h00
`define CRS_REG_FRAME_START 5'h01
`define CRS_REG_FRAME_INPUT 5'h02
`define CRS_REG_FRAME_READBACK 5'h03
`define CRS_REG_COMMAND 5'h04
`define CRS_REG_CONTROL 5'h05
`define CRS_REG_MASK 5'h06
`define CRS_REG_STATUS 5'h07
`define CRS_REG_CHAIN_OUT 5'h08
`define CRS_REG_OPTION 5'h09
`define CRS_REG_FRAME_LEN 5'h0b
`define CRS_REG_IDENTITY 5'h0e
// command codes
`define CRS_CMD_WRITE_FRAMES 4'h1
`define CRS_CMD_RELEASE_GLOBAL_HIGH 4'h3
`define CRS_CMD_START 4'h5
`define CRS_CMD_CHECKSUM_RESET 4'h7
`define CRS_CMD_SWITCH 4'h9
`define CRS_CMD_WORD_DESYNC 4'hd
// control register fields
`define CRS_CTL_USER_GTS 0
`define CRS_CTL_PORTS_RETAINED 3
`define CRS_CTL_SEC_LO 4
`define CRS_CTL_SEC_HI 5
// option register clock select field
`define CRS_OPT_FREQ_HI 22
`define CRS_OPT_FREQ_LO 17
// status register bit positions
`define CRS_ST_CRC_ERR 0
`define CRS_ST_CM_LOCK 2
`define CRS_ST_IC_MATCH 3
`define CRS_ST_IN_ERR 4
`define CRS_ST_CFG_GTS 5
`define CRS_ST_GWE 6
`define CRS_ST_GHIGH 7
`define CRS_ST_MODE_LO 8
`define CRS_ST_MODE_HI 10
`define CRS_ST_INIT 11
`define CRS_ST_DONE 12
`define CRS_ST_ID_ERR 13
// framing and checksum
`define CRS_SYNC_WORD 32'h5a3c_c35a
`define CRS_BIT_LAST 5'h1f
`define CRS_CRC_POLY 16'h8005
`define CRS_CRC_INIT 16'h0000
`endif

// File: rtl/crs_link_rx.v
// serial link sampler, sync word hunter and word assembler
`timescale 1ns/1ps
`include "crs_defines.vh"
module crs_link_rx (
	mclk,
	rst,
	config_clock,
	cfg_data_in,
	desync,
	word_data,
	word_valid,
	clk_rise,
	synced
);
	input wire mclk;
	input wire rst;
	input wire config_clock; // link clock pin, sampled
	input wire cfg_data_in; // serial data pin
	input wire desync; // forces a new hunt
	output reg [31:0] word_data;
	output reg word_valid; // one-cycle pulse
	output reg clk_rise; // one-cycle pulse per rising link edge
	output reg synced;
	reg [1:0] clk_meta_q; // [0] read only by [1]
	reg [1:0] dat_meta_q;
	reg clk_prev_q;
	reg [31:0] shift_q;
	reg [4:0] bit_q;
	wire [31:0] next_shift;
	assign next_shift = {shift_q[30:0], dat_meta_q[1]};
	// two-stage synchronisers plus edge history
	always @(posedge mclk) begin
		if (rst) begin
			clk_meta_q <= 2'h0;
			dat_meta_q <= 2'h0;
			clk_prev_q <= 1'b0;
		end else begin
			clk_meta_q <= {clk_meta_q[0], config_clock};
			dat_meta_q <= {dat_meta_q[0], cfg_data_in};
			clk_prev_q <= clk_meta_q[1];
		end
	end
	// data is taken on the rising link edge; dummy words fall out unseen
	always @(posedge mclk) begin
		if (rst) begin
			shift_q <= 32'h0;
			bit_q <= 5'h0;
			synced <= 1'b0;
			word_valid <= 1'b0;
			word_data <= 32'h0;
			clk_rise <= 1'b0;
		end else begin
			word_valid <= 1'b0;
			clk_rise <= clk_meta_q[1] & ~clk_prev_q;
			if (desync) begin
				synced <= 1'b0; // [RULE_24]
			end else if (clk_meta_q[1] & ~clk_prev_q) begin
				shift_q <= next_shift;
				if (!synced) begin
					// nothing passes on until the sync word is seen
					if (next_shift == `CRS_SYNC_WORD) begin // [RULE_26]
						synced <= 1'b1; // [RULE_15]
						bit_q <= 5'h0;
					end
				end else begin
					bit_q <= bit_q + 5'h1;
					if (bit_q == `CRS_BIT_LAST) begin // [RULE_15]
						word_data <= next_shift;
						word_valid <= 1'b1;
					end
				end
			end
		end
	end
endmodule // crs_link_rx

// File: rtl/crs_fifo.v
// word fifo between link and packet processor
`timescale 1ns/1ps
module crs_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	mclk,
	rst,
	in_data,
	in_valid,
	in_ready,
	out_data,
	out_valid,
	out_ready
);
	input wire mclk;
	input wire rst;
	input wire [WIDTH-1:0] in_data;
	input wire in_valid;
	output wire in_ready; // low while full
	output wire [WIDTH-1:0] out_data;
	output wire out_valid; // high while not empty
	input wire out_ready;
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready = (cnt_q != DEPTH);
	assign out_valid = (cnt_q != 0);
	assign out_data = mem[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	// storage write, no reset needed
	always @(posedge mclk) begin
		if (push)
			mem[wr_q] <= in_data;
	end
	// pointers and fill count
	always @(posedge mclk) begin
		if (rst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // crs_fifo

// File: rtl/crs_top.v
// configuration register sequencer: packet decode, registers, frames
// Behaviour
// [RULE_01] control holds security level, persistence, user tristate
// [RULE_02] control bit 3 keeps ports after configuration
// [RULE_03] bit 0 user tristate; both asserted disables pullups
// [RULE_04] control write changes only mask-enabled bits
// [RULE_05] frame pointer starts next frame input write
// [RULE_06] frames written from pointer, pointer steps each frame
// [RULE_07] written checksum compared, mismatch sets status bit 0
// [RULE_08] readback port reads frames like input path
// [RULE_09] chain output register shifts data to data-out
// [RULE_10] status read-only, readable on port, writes ignored
// [RULE_11] frame write without validated identity sets bit 13
// [RULE_12] status shows done, init and mode pins
// [RULE_13] status shows global high, write enable, tristate
// [RULE_14] status shows input error, calibration, clock lock
// [RULE_15] dummy then sync word sets word boundaries
// [RULE_16] source resets checksum, loads length and options
// [RULE_17] clock select applies only on switch command
// [RULE_18] identity register written checks bitstream matches
// [RULE_19] write-frames command enables frame memory writes
// [RULE_20] source sends checksum then releases global high
// [RULE_21] source sends start, control, checksum, desync
// [RULE_22] source sends four trailing dummy words
// [RULE_23] codes: write frames, checksum reset, switch
// [RULE_24] codes: release high, start, desync realigns words
// [RULE_25] type one header: type, op, address, count
// [RULE_26] nothing processed before sync word recognised
// [RULE_27] error bits stay until reset command or resync
`timescale 1ns/1ps
`include "crs_defines.vh"
module crs_top #(
	parameter FA_W = 4, // frame pointer bits held in memory
	parameter FW_W = 4, // word-in-frame bits held in memory
	parameter FIFO_DEPTH = 16,
	parameter [31:0] DEVICE_IDENTITY = 32'h0123_4567 // arbitrary value
) (
	mclk,
	rst,
	config_clock,
	cfg_data_in,
	done_pin,
	init_pin,
	mode_pins,
	in_error_pin,
	impedance_cal_matched,
	clock_manager_locked,
	rb_ready,
	rb_data_q,
	rb_valid_q,
	chain_data_out_q,
	config_status_q,
	global_high_n_q,
	global_write_enable_q,
	cfg_global_tristate_n_q,
	io_tristate_q,
	pullups_off_q,
	security_level_q,
	ports_active_q,
	clk_freq_sel_q,
	overrun_q
);
	input wire mclk;
	input wire rst;
	input wire config_clock;
	input wire cfg_data_in;
	input wire done_pin;
	input wire init_pin;
	input wire [2:0] mode_pins;
	input wire in_error_pin;
	input wire impedance_cal_matched;
	input wire clock_manager_locked;
	input wire rb_ready;
	output reg [31:0] rb_data_q;
	output reg rb_valid_q;
	output reg chain_data_out_q;
	output reg [31:0] config_status_q;
	output reg global_high_n_q;
	output reg global_write_enable_q;
	output reg cfg_global_tristate_n_q;
	output reg io_tristate_q;
	output reg pullups_off_q;
	output reg [1:0] security_level_q;
	output reg ports_active_q;
	output reg [5:0] clk_freq_sel_q;
	output reg overrun_q;

	localparam S_HDR = 3'b001; // waiting for a header
	localparam S_WDATA = 3'b010; // taking write data words
	localparam S_READ = 3'b100; // emitting read words

	// checksum over register address and data, bit-serial
	function [15:0] crc_step;
		input [15:0] crc;
		input [4:0] addr;
		input [31:0] data;
		reg [36:0] bits;
		reg [15:0] c;
		integer i;
		begin
			bits = {addr, data};
			c = crc;
			for (i = 36; i >= 0; i = i - 1) begin
				if (c[15] ^ bits[i])
					c = {c[14:0], 1'b0} ^ `CRS_CRC_POLY;
				else
					c = {c[14:0], 1'b0};
			end
			crc_step = c;
		end
	endfunction

	wire [31:0] lw_data;
	wire lw_valid;
	wire link_rise;
	wire link_synced;
	wire fifo_in_ready;
	wire [31:0] pw_data;
	wire pw_valid;
	wire pw_pop;
	reg desync_q; // pulse back to the link side
	reg [7:0] pin_meta_q; // first stage, read only by the second
	reg [7:0] pin_q; // synchronised status pins
	reg [2:0] state_q;
	reg [4:0] cur_addr_q; // register addressed by last header
	reg [1:0] cur_op_q;
	reg [26:0] cnt_q; // words left in packet
	reg [31:0] control_q;
	reg [31:0] mask_q;
	reg [31:0] option_q;
	reg [31:0] frame_len_q;
	reg [31:0] frame_start_pointer_q;
	reg [31:0] word_in_frame_q;
	reg [15:0] crc_q;
	reg crc_error_q;
	reg identity_mismatch_q;
	reg identity_ok_q;
	reg write_frames_q;
	reg [31:0] chain_shift_q;
	reg [5:0] chain_bits_q;
	reg [31:0] frame_mem [0:(1<<(FA_W+FW_W))-1];
	wire [FA_W+FW_W-1:0] mem_idx;
	wire frame_end;
	wire [31:0] status_now;

	crs_link_rx u_link (
		.mclk(mclk),
		.rst(rst),
		.config_clock(config_clock),
		.cfg_data_in(cfg_data_in),
		.desync(desync_q),
		.word_data(lw_data),
		.word_valid(lw_valid),
		.clk_rise(link_rise),
		.synced(link_synced)
	);

	// buffers words while readback stalls the processor
	crs_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_data(lw_data),
		.in_valid(lw_valid),
		.in_ready(fifo_in_ready),
		.out_data(pw_data),
		.out_valid(pw_valid),
		.out_ready(pw_pop)
	);

	// shared frame pointer for input and readback
	assign mem_idx = {frame_start_pointer_q[FA_W-1:0],
		word_in_frame_q[FW_W-1:0]}; // [RULE_05] [RULE_08]
	assign frame_end = (word_in_frame_q + 32'h1 >= frame_len_q);
	assign pw_pop = (state_q != S_READ);
	assign status_now = {18'h0, identity_mismatch_q, pin_q[0], pin_q[1],
		pin_q[4:2], global_high_n_q, global_write_enable_q,
		cfg_global_tristate_n_q, pin_q[5], pin_q[6], pin_q[7],
		1'b0, crc_error_q}; // [RULE_12] [RULE_13] [RULE_14]

	// status pins cross into mclk through two flops
	always @(posedge mclk) begin
		if (rst) begin
			pin_meta_q <= 8'h0;
			pin_q <= 8'h0;
		end else begin
			pin_meta_q <= {clock_manager_locked, impedance_cal_matched,
				in_error_pin, mode_pins, init_pin, done_pin};
			pin_q <= pin_meta_q;
		end
	end

	// frame memory write from input path
	always @(posedge mclk) begin
		if (state_q == S_WDATA && pw_valid &&
			cur_addr_q == `CRS_REG_FRAME_INPUT && cur_op_q == `CRS_OP_WRITE &&
			identity_ok_q && write_frames_q)
			frame_mem[mem_idx] <= pw_data; // [RULE_06] [RULE_19]
	end

	// packet decode and register file
	always @(posedge mclk) begin
		if (rst) begin
			state_q <= S_HDR;
			cur_addr_q <= 5'h0;
			cur_op_q <= 2'h0;
			cnt_q <= 27'h0;
			control_q <= 32'h0;
			mask_q <= 32'h0;
			option_q <= 32'h0;
			frame_len_q <= 32'h1;
			frame_start_pointer_q <= 32'h0;
			word_in_frame_q <= 32'h0;
			crc_q <= `CRS_CRC_INIT;
			crc_error_q <= 1'b0;
			identity_mismatch_q <= 1'b0;
			identity_ok_q <= 1'b0;
			write_frames_q <= 1'b0;
			desync_q <= 1'b0;
			global_high_n_q <= 1'b0;
			global_write_enable_q <= 1'b0;
			cfg_global_tristate_n_q <= 1'b0;
			clk_freq_sel_q <= 6'h0;
			rb_data_q <= 32'h0;
			rb_valid_q <= 1'b0;
			chain_shift_q <= 32'h0;
			chain_bits_q <= 6'h0;
		end else begin
			desync_q <= 1'b0;
			// the desync command clears the identity error; a set in the same cycle wins
			if (desync_q)
				identity_mismatch_q <= 1'b0; // [RULE_27]
			// chain output shifts on each link rising edge until all 32 loaded bits are out
			if (link_rise && chain_bits_q != 6'h0) begin
				chain_shift_q <= {chain_shift_q[30:0], 1'b0}; // [RULE_09]
				chain_bits_q <= chain_bits_q - 6'h1;
			end
			case (state_q)
			S_HDR: begin
				if (pw_valid) begin
					if (pw_data[`CRS_HDR_TYPE_HI:`CRS_HDR_TYPE_LO] ==
						`CRS_TYPE_ONE) begin // [RULE_25]
						cur_addr_q <= pw_data[`CRS_HDR_ADDR_HI:`CRS_HDR_ADDR_LO];
						cur_op_q <= pw_data[`CRS_HDR_OP_HI:`CRS_HDR_OP_LO];
						cnt_q <= {16'h0, pw_data[`CRS_HDR_CNT1_HI:0]};
						if (pw_data[`CRS_HDR_CNT1_HI:0] != 11'h0)
							state_q <= (pw_data[`CRS_HDR_OP_HI:`CRS_HDR_OP_LO] ==
								`CRS_OP_READ) ? S_READ : S_WDATA;
					end else if (pw_data[`CRS_HDR_TYPE_HI:`CRS_HDR_TYPE_LO] ==
						`CRS_TYPE_TWO &&
						pw_data[`CRS_HDR_CNT2_HI:0] != 27'h0) begin
						// long count for the register named before
						cnt_q <= pw_data[`CRS_HDR_CNT2_HI:0];
						state_q <= (cur_op_q == `CRS_OP_READ) ? S_READ : S_WDATA;
					end
				end
			end
			S_WDATA: begin
				if (pw_valid) begin
					cnt_q <= cnt_q - 27'h1;
					if (cnt_q == 27'h1)
						state_q <= S_HDR;
					if (cur_addr_q != `CRS_REG_CHECKSUM)
						crc_q <= crc_step(crc_q, cur_addr_q, pw_data);
					case (cur_addr_q)
					`CRS_REG_CHECKSUM: begin
						if (pw_data[15:0] != crc_q)
							crc_error_q <= 1'b1; // [RULE_07] [RULE_27]
					end
					`CRS_REG_FRAME_START: begin
						frame_start_pointer_q <= pw_data; // [RULE_05]
						word_in_frame_q <= 32'h0;
					end
					`CRS_REG_FRAME_INPUT: begin
						if (!identity_ok_q)
							identity_mismatch_q <= 1'b1; // [RULE_11] [RULE_27]
						else if (write_frames_q) begin
							// step the pointer at each frame boundary
							if (frame_end) begin // [RULE_06]
								word_in_frame_q <= 32'h0;
								frame_start_pointer_q <= frame_start_pointer_q + 32'h1;
							end else
								word_in_frame_q <= word_in_frame_q + 32'h1;
						end
					end
					`CRS_REG_COMMAND: begin
						case (pw_data[3:0]) // [RULE_23] [RULE_24]
						`CRS_CMD_WRITE_FRAMES: write_frames_q <= 1'b1; // [RULE_19]
						`CRS_CMD_CHECKSUM_RESET: begin
							// clears the sum and its sticky error
							crc_q <= `CRS_CRC_INIT;
							crc_error_q <= 1'b0; // [RULE_27]
						end
						`CRS_CMD_SWITCH: clk_freq_sel_q <=
							option_q[`CRS_OPT_FREQ_HI:`CRS_OPT_FREQ_LO]; // [RULE_17]
						`CRS_CMD_RELEASE_GLOBAL_HIGH: global_high_n_q <= 1'b1;
						`CRS_CMD_START: begin
							global_write_enable_q <= 1'b1;
							cfg_global_tristate_n_q <= 1'b1;
						end
						`CRS_CMD_WORD_DESYNC: begin
							// realign: drop frame writes, hunt sync again
							desync_q <= 1'b1; // [RULE_24]
							write_frames_q <= 1'b0;
							state_q <= S_HDR;
						end
						default: write_frames_q <= write_frames_q;
						endcase
					end
					`CRS_REG_CONTROL: control_q <= (control_q & ~mask_q) |
						(pw_data & mask_q); // [RULE_04]
					`CRS_REG_MASK: mask_q <= pw_data;
					`CRS_REG_CHAIN_OUT: begin
						chain_shift_q <= pw_data; // [RULE_09]
						chain_bits_q <= 6'h20;
					end
					`CRS_REG_OPTION: option_q <= pw_data;
					`CRS_REG_FRAME_LEN: frame_len_q <= pw_data;
					`CRS_REG_IDENTITY: begin
						identity_ok_q <= (pw_data == DEVICE_IDENTITY); // [RULE_18]
						if (pw_data != DEVICE_IDENTITY)
							identity_mismatch_q <= 1'b1;
					end
					// status and unknown addresses ignore writes
					default: mask_q <= mask_q; // [RULE_10]
					endcase
				end
			end
			S_READ: begin
				// next word only when the reader took the last one
				if (!rb_valid_q || rb_ready) begin
					if (cnt_q == 27'h0) begin
						rb_valid_q <= 1'b0;
						state_q <= S_HDR;
					end else begin
						rb_valid_q <= 1'b1;
						cnt_q <= cnt_q - 27'h1;
						case (cur_addr_q)
						`CRS_REG_STATUS: rb_data_q <= status_now; // [RULE_10]
						`CRS_REG_FRAME_READBACK: begin
							rb_data_q <= frame_mem[mem_idx]; // [RULE_08]
							if (frame_end) begin
								word_in_frame_q <= 32'h0;
								frame_start_pointer_q <= frame_start_pointer_q + 32'h1;
							end else
								word_in_frame_q <= word_in_frame_q + 32'h1;
						end
						`CRS_REG_CONTROL: rb_data_q <= control_q;
						`CRS_REG_OPTION: rb_data_q <= option_q;
						`CRS_REG_FRAME_START: rb_data_q <= frame_start_pointer_q;
						default: rb_data_q <= 32'h0;
						endcase
					end
				end
			end
			default: state_q <= S_HDR;
			endcase
		end
	end

	// derived outputs, each straight from a flop
	always @(posedge mclk) begin
		if (rst) begin
			config_status_q <= 32'h0;
			io_tristate_q <= 1'b1;
			pullups_off_q <= 1'b0;
			security_level_q <= 2'h0;
			ports_active_q <= 1'b1;
			chain_data_out_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			config_status_q <= status_now; // [RULE_10]
			io_tristate_q <= ~control_q[`CRS_CTL_USER_GTS] |
				~cfg_global_tristate_n_q; // [RULE_03]
			pullups_off_q <= ~control_q[`CRS_CTL_USER_GTS] &
				~cfg_global_tristate_n_q; // [RULE_03]
			security_level_q <=
				control_q[`CRS_CTL_SEC_HI:`CRS_CTL_SEC_LO]; // [RULE_01]
			// ports drop after startup unless retained
			ports_active_q <= ~global_write_enable_q |
				control_q[`CRS_CTL_PORTS_RETAINED]; // [RULE_02]
			chain_data_out_q <= chain_shift_q[31];
			// the link cannot be stalled, so a full buffer loses a word
			if (lw_valid && !fifo_in_ready)
				overrun_q <= 1'b1;
			else if (!link_synced)
				overrun_q <= 1'b0;
		end
	end
endmodule // crs_top

// File: test/crs_src_model.sv
// serial configuration source driving link clock and data pin
`timescale 1ns/1ps
`include "crs_defines.vh"
module crs_src_model (
	output reg config_clock,
	output reg cfg_data_in
);
	integer i; // bit being sent
	// link clock stands low between words
	initial begin
		config_clock = 1'b0;
		cfg_data_in = 1'b1;
	end
	// one word msb first; data moves only while the clock is low
	task send_word(input [31:0] w);
		begin
			for (i = 31; i >= 0; i = i - 1) begin
				cfg_data_in = w[i];
				#32 config_clock = 1'b1;
				#32 config_clock = 1'b0;
			end
			cfg_data_in = ~w[0]; // no pull on the pin: never the last bit
		end
	endtask
	// pad word for start clocks, then the boundary marker
	task preamble;
		begin
			send_word(32'hffff_ffff);
			send_word(`CRS_SYNC_WORD);
		end
	endtask
	// closing pad words give the last link clocks
	task trailer;
		integer n; // pad count
		begin
			for (n = 0; n < 4; n = n + 1) send_word(32'hffff_ffff);
		end
	endtask
endmodule // crs_src_model

// File: test/crs_top_monitor.sv
// port-level checks for the configuration register sequencer
`timescale 1ns/1ps
module crs_mon (
	input wire mclk,
	input wire rst,
	input wire config_clock,
	input wire done_pin,
	input wire init_pin,
	input wire [2:0] mode_pins,
	input wire in_error_pin,
	input wire impedance_cal_matched,
	input wire clock_manager_locked,
	input wire rb_ready,
	input wire [31:0] rb_data_q,
	input wire rb_valid_q,
	input wire chain_data_out_q,
	input wire [31:0] config_status_q,
	input wire global_high_n_q,
	input wire global_write_enable_q,
	input wire cfg_global_tristate_n_q,
	input wire io_tristate_q,
	input wire pullups_off_q,
	input wire ports_active_q
);
	reg [1:0] lk_q; // link clock samples, newest in bit 0
	reg [3:0] since_rise_q; // cycles since a link rise, saturating
	// age of the last link edge; a chain step needs a fresh one
	always @(posedge mclk) begin
		lk_q <= {lk_q[0], config_clock};
		if (rst || lk_q == 2'b01) begin
			since_rise_q <= 4'h0;
		end else if (since_rise_q != 4'hf) begin
			since_rise_q <= since_rise_q + 4'h1;
		end
	end
	default clocking mon_cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// pins take three flops to reach status
	sequence s_pins_steady;
		$stable({done_pin, init_pin, mode_pins})[*8];
	endsequence
	sequence s_health_steady;
		$stable({in_error_pin, impedance_cal_matched,
			clock_manager_locked})[*8];
	endsequence
	a_pin_status: assert property (s_pins_steady |->
		config_status_q[12:8] == {done_pin, init_pin, mode_pins})
		else $error("status pin fields wrong");
	a_health_status: assert property (s_health_steady |->
		config_status_q[4:2] == {in_error_pin, impedance_cal_matched,
		clock_manager_locked})
		else $error("status health fields wrong");
	a_status_globals: assert property (
		config_status_q[7:5] == $past({global_high_n_q,
		global_write_enable_q, cfg_global_tristate_n_q}))
		else $error("status global fields wrong");
	a_status_reserved: assert property (
		config_status_q[31:14] == 18'h0 && !config_status_q[1])
		else $error("reserved status bits set");
	a_rb_hold: assert property (
		rb_valid_q && !rb_ready |=> rb_valid_q && $stable(rb_data_q))
		else $error("read word lost before accepted");
	a_chain_link: assert property (
		$changed(chain_data_out_q) |-> since_rise_q < 4'he)
		else $error("chain output moved without link edge");
	a_ports_kept: assert property (
		!ports_active_q |-> global_write_enable_q ||
		$past(global_write_enable_q))
		else $error("ports released while write enable low");
	a_pullups_gate: assert property (
		pullups_off_q |-> (io_tristate_q || $past(io_tristate_q)) &&
		(!cfg_global_tristate_n_q || $past(!cfg_global_tristate_n_q)))
		else $error("pullups off without both tristates");
endmodule // crs_mon
bind crs_top crs_mon u_crs_mon (.*);

// File: test/crs_top_tb_top.sv
// self-checking bench for the configuration register sequencer
`timescale 1ns/1ps
`include "crs_defines.vh"
module crs_top_tb_top;
	localparam [31:0] DEV_ID = 32'h0123_4567; // arbitrary value
	reg mclk, rst, rb_ready; // clock, reset, reader accept
	reg done_pin, init_pin, in_error_pin; // status pins
	reg impedance_cal_matched, clock_manager_locked; // health pins
	reg [2:0] mode_pins; // mode straps
	wire config_clock, cfg_data_in; // link from the source model
	wire [31:0] rb_data_q, config_status_q; // read word, status copy
	wire rb_valid_q, chain_data_out_q, overrun_q; // read, chain, buffer
	wire global_high_n_q, global_write_enable_q, cfg_global_tristate_n_q;
	wire io_tristate_q, pullups_off_q, ports_active_q; // pad controls
	wire [1:0] security_level_q; // control bits 5:4
	wire [5:0] clk_freq_sel_q; // applied clock select
	integer n_fail, num_checks; // mismatches, comparisons
	reg [31:0] rd_q; // last accepted read word
	crs_src_model u_crs_src_model (
		.config_clock(config_clock),
		.cfg_data_in(cfg_data_in)
	);
	crs_top #(.DEVICE_IDENTITY(DEV_ID)) u_crs_top (
		.mclk(mclk), .rst(rst), .config_clock(config_clock),
		.cfg_data_in(cfg_data_in), .done_pin(done_pin),
		.init_pin(init_pin), .mode_pins(mode_pins),
		.in_error_pin(in_error_pin),
		.impedance_cal_matched(impedance_cal_matched),
		.clock_manager_locked(clock_manager_locked),
		.rb_ready(rb_ready), .rb_data_q(rb_data_q),
		.rb_valid_q(rb_valid_q), .chain_data_out_q(chain_data_out_q),
		.config_status_q(config_status_q),
		.global_high_n_q(global_high_n_q),
		.global_write_enable_q(global_write_enable_q),
		.cfg_global_tristate_n_q(cfg_global_tristate_n_q),
		.io_tristate_q(io_tristate_q), .pullups_off_q(pullups_off_q),
		.security_level_q(security_level_q),
		.ports_active_q(ports_active_q),
		.clk_freq_sel_q(clk_freq_sel_q), .overrun_q(overrun_q)
	);
	// system clock, 4 ns period
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// type one header word
	function [31:0] hdr(input [1:0] op, input [4:0] a, input [10:0] n);
		hdr = {`CRS_TYPE_ONE, op, 9'h0, a, 2'h0, n};
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("unexpected %s: expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task summarize;
		begin
			if (n_fail == 0 && num_checks > 0) begin
				$display("No errors found");
			end else begin
				$display("Errors were found");
			end
			$finish;
		end
	endtask
	// one link word, then decode time
	task word(input [31:0] w);
		begin
			u_crs_src_model.send_word(w);
			repeat (12) @(posedge mclk);
			#1;
		end
	endtask
	task wr(input [4:0] a, input [31:0] d);
		begin
			word(hdr(`CRS_OP_WRITE, a, 11'h1));
			word(d);
		end
	endtask
	task cmd(input [3:0] c);
		wr(`CRS_REG_COMMAND, {28'h0, c});
	endtask
	// take one read word: hold ready until the edge that accepts it
	task rd_word;
		integer k; // bounded wait
		begin
			for (k = 0; k < 2000 && rb_valid_q !== 1'b1; k = k + 1) begin
				@(posedge mclk);
				#1;
			end
			if (k == 2000) begin
				n_fail = n_fail + 1;
				summarize;
			end
			rd_q = rb_data_q;
			rb_ready = 1'b1;
			@(posedge mclk);
			#1 rb_ready = 1'b0;
		end
	endtask
	task rd_status;
		begin
			word(hdr(`CRS_OP_READ, `CRS_REG_STATUS, 11'h1));
			rd_word;
		end
	endtask
	// writes before sync change nothing
	task sc_pre_sync;
		begin
			wr(`CRS_REG_MASK, 32'h0000_003f);
			wr(`CRS_REG_CONTROL, 32'h0000_0030);
			chk("security_level_q", 32'h0, {30'h0, security_level_q});
		end
	endtask
	// clock select waits for the switch command
	task sc_setup;
		begin
			cmd(`CRS_CMD_CHECKSUM_RESET);
			wr(`CRS_REG_FRAME_LEN, 32'h0000_0001);
			wr(`CRS_REG_OPTION, 32'h0054_0000);
			chk("clk_freq_sel_q", 32'h0, {26'h0, clk_freq_sel_q});
			cmd(`CRS_CMD_SWITCH);
			chk("clk_freq_sel_q", 32'h2a, {26'h0, clk_freq_sel_q});
		end
	endtask
	// frame data before identity, status write
	task sc_id_err;
		begin
			wr(`CRS_REG_FRAME_INPUT, 32'h1234_5678);
			rd_status;
			chk("status", 32'h0000_3d14, rd_q);
			done_pin = 1'b0;
			mode_pins = 3'h2;
			impedance_cal_matched = 1'b1;
			wr(`CRS_REG_STATUS, 32'hffff_ffff);
			rd_status;
			chk("status", 32'h0000_2a1c, rd_q);
		end
	endtask
	// only mask-enabled control bits may move
	task sc_ctl;
		begin
			wr(`CRS_REG_IDENTITY, DEV_ID);
			wr(`CRS_REG_MASK, 32'h0000_0010);
			wr(`CRS_REG_CONTROL, 32'h0000_003f);
			chk("security_level_q", 32'h1, {30'h0, security_level_q});
			wr(`CRS_REG_MASK, 32'h0000_0039);
			wr(`CRS_REG_CONTROL, 32'h0000_0028);
			chk("security_level_q", 32'h2, {30'h0, security_level_q});
			chk("pullups_off_q", 32'h1, {31'h0, pullups_off_q});
			wr(`CRS_REG_CONTROL, 32'h0000_0001);
			chk("io_tristate_q", 32'h1, {31'h0, io_tristate_q});
		end
	endtask
	// two one-word frames from pointer 3, read back
	task sc_frames;
		begin
			cmd(`CRS_CMD_WRITE_FRAMES);
			wr(`CRS_REG_FRAME_START, 32'h0000_0003);
			word(hdr(`CRS_OP_WRITE, `CRS_REG_FRAME_INPUT, 11'h2));
			word(32'hc0de_0001);
			word(32'hc0de_0002);
			wr(`CRS_REG_FRAME_START, 32'h0000_0003);
			word(hdr(`CRS_OP_READ, `CRS_REG_FRAME_READBACK, 11'h2));
			rd_word;
			chk("first frame", 32'hc0de_0001, rd_q);
			rd_word;
			chk("second frame", 32'hc0de_0002, rd_q);
			wr(`CRS_REG_CHAIN_OUT, 32'h8000_0001);
		end
	endtask
	// wrong checksum flags an error until the reset command
	task sc_crc;
		begin
			wr(`CRS_REG_CHECKSUM, 32'h0000_0000);
			rd_status;
			chk("checksum error", 32'h1, {31'h0, rd_q[0]});
			cmd(`CRS_CMD_CHECKSUM_RESET);
			rd_status;
			chk("checksum error", 32'h0, {31'h0, rd_q[0]});
		end
	endtask
	// stalled reader fills the buffer
	task sc_fifo;
		integer j; // filler words sent
		begin
			word(hdr(`CRS_OP_READ, `CRS_REG_STATUS, 11'h2));
			for (j = 0; j < 18; j = j + 1) begin
				if (j == 15) chk("overrun_q", 32'h0, {31'h0, overrun_q});
				word(hdr(`CRS_OP_WRITE, `CRS_REG_STATUS, 11'h0));
			end
			chk("overrun_q", 32'h1, {31'h0, overrun_q});
			rd_word;
			rd_word;
			cmd(`CRS_CMD_WORD_DESYNC);
			chk("overrun_q", 32'h0, {31'h0, overrun_q});
		end
	endtask
	// closing commands; writes after desync ignored
	task sc_finish;
		begin
			u_crs_src_model.preamble;
			cmd(`CRS_CMD_CHECKSUM_RESET);
			wr(`CRS_REG_CHECKSUM, 32'h0000_0000);
			cmd(`CRS_CMD_RELEASE_GLOBAL_HIGH);
			chk("global_high_n_q", 32'h1, {31'h0, global_high_n_q});
			cmd(`CRS_CMD_START);
			wr(`CRS_REG_CONTROL, 32'h0000_0001);
			wr(`CRS_REG_CHECKSUM, 32'h0000_0000);
			cmd(`CRS_CMD_WORD_DESYNC);
			u_crs_src_model.trailer;
			wr(`CRS_REG_MASK, 32'h0000_003f);
			wr(`CRS_REG_CONTROL, 32'h0000_0030);
			chk("security_level_q", 32'h0, {30'h0, security_level_q});
		end
	endtask
	// reset, pin levels, then the scenarios in order
	initial begin
		n_fail = 0;
		num_checks = 0;
		rst = 1'b1;
		rb_ready = 1'b0;
		done_pin = 1'b1;
		init_pin = 1'b1;
		mode_pins = 3'h5;
		in_error_pin = 1'b1;
		impedance_cal_matched = 1'b0;
		clock_manager_locked = 1'b1;
		repeat (6) @(posedge mclk);
		#1 rst = 1'b0;
		repeat (4) @(posedge mclk);
		sc_pre_sync;
		u_crs_src_model.preamble;
		sc_setup;
		sc_id_err;
		sc_ctl;
		sc_frames;
		sc_crc;
		sc_fifo;
		sc_finish;
		summarize;
	end
endmodule // crs_top_tb_top
